// file: pnprc_params.svh
// register offsets, reset values, masks and field positions for the pnp resource bank
`ifndef PNPRC_PARAMS_SVH
`define PNPRC_PARAMS_SVH
`define PNPRC_IDX_UBBASE   8'h25
`define PNPRC_IDX_DMASEL   8'h26
`define PNPRC_IDX_PRTIRQ   8'h27
`define PNPRC_IDX_UARTIRQ  8'h28
`define PNPRC_IDX_FDIRQ    8'h29
`define PNPRC_IDX_CLKSEL   8'h2C
`define PNPRC_IDX_FDRATE   8'h2D
`define PNPRC_DEF1_UBBASE  8'hBE
`define PNPRC_DEF1_DMASEL  8'h23
`define PNPRC_DEF1_PRTIRQ  8'h05
`define PNPRC_DEF1_UARTIRQ 8'h43
`define PNPRC_DEF1_FDIRQ   8'h62
`define PNPRC_DEF0         8'h00
`define PNPRC_RST_CLKSEL   8'h00
`define PNPRC_RST_FDRATE   8'h00
`define PNPRC_MASK_UBBASE  8'hFE
`define PNPRC_MASK_PRTIRQ  8'hEF
`define PNPRC_MASK_CLKSEL  8'h04
`define PNPRC_MASK_FDRATE  8'h3F
`define PNPRC_MASK_FULL    8'hFF
`define PNPRC_CLK48_BIT    2
`define PNPRC_PCB_B_BIT    5
`define PNPRC_PCA_A_BIT    2
`define PNPRC_SLOT_SMI     4'h2
`define PNPRC_SEL_NONE     4'h0
`endif

// file: pnprc_pkg.sv
// shared types of the pnp resource bank
package pnprc_pkg;
    // operational floppy data rate, invalid where fm has no rate
    typedef enum logic [2:0] {
        PNPRC_R2M, PNPRC_R1M, PNPRC_R500K, PNPRC_R300K,
        PNPRC_R250K, PNPRC_R150K, PNPRC_R125K, PNPRC_RBAD
    } pnprc_rate_t;
    // access phase of the config data port
    typedef enum logic [1:0] {
        PNPRC_IDLE, PNPRC_WRITE, PNPRC_READ
    } pnprc_acc_t;
endpackage : pnprc_pkg

// file: pnprc_regs.sv
// pnp resource configuration registers with decode, irq, dma and floppy rate logic
//
// Contract
// - access only in extended mode, matching index
// - uart b base compares address bits 9..3
// - claim needs chip select low, a10 low
// - base bits 7,6 zero disable decode
// - base bit 0 always zero
// - base, dma defaults follow defaults select
// - irq register defaults follow defaults select
// - dma nibbles pick floppy, printer channel
// - reported irq mirrored to ecp config b
// - bits 7..5 report assigned irq number
// - legacy nibble routes to pins, others tristate
// - serial mode tristates all eight pins
// - serial mode nibble selects frame slot
// - uart register nibbles serve uart a, b
// - floppy nibble and external input nibble
// - clock bit 2 selects 24 or 48 mhz
// - precomp disable bits for drives b, a
// - rate code 00 gives standard rate table
// - codes 01, 10 alter rate select 01
`timescale 1ns/1ps
`default_nettype none
`include "pnprc_params.svh"

module pnprc_regs
    import pnprc_pkg::*;
#(
    parameter int ADDR_W = 11  // host address width, a10 is the top bit
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ext_mode_active,
    input  wire logic              config_index_port_wr,
    input  wire logic              config_data_port_wr,
    input  wire logic              config_data_port_rd,
    input  wire logic [7:0]        host_wdata,
    output logic      [7:0]        config_rdata_q,
    input  wire logic              defaults_select_bit,
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic              chip_select_low_n,
    output logic                   second_serial_claim_q,
    input  wire logic              serial_interrupt_mode,
    input  wire logic              printer_irq,
    input  wire logic              first_serial_irq,
    input  wire logic              second_serial_irq,
    input  wire logic              floppy_irq,
    input  wire logic              external_interrupt_input,
    output logic      [7:0]        irq_pin_out_q,
    output logic      [7:0]        irq_pin_oe_q,
    output logic      [15:0]       serial_irq_slot_q,
    input  wire logic              floppy_dma_req,
    input  wire logic              printer_dma_req,
    output logic      [2:0]        dma_channel_req_q,
    output logic      [2:0]        ecp_configuration_b_irq_q,
    output logic                   input_clock_48m_q,
    input  wire logic              floppy_drive_b,
    input  wire logic              rate_select_high,
    input  wire logic              rate_select_low,
    input  wire logic              floppy_fm_mode,
    output pnprc_rate_t            floppy_rate_q,
    output logic                   floppy_precomp_en_q
);

    // address width must reach a10 and the base field; refused at elaboration
    if (ADDR_W != 11) begin : g_bad_addr_w
        $error("pnprc_regs: ADDR_W must be 11");
    end

    logic [7:0]  index_q;         // config index register
    logic [7:0]  ubbase_q;        // uart b base address
    logic [7:0]  dmasel_q;        // dma channel select
    logic [7:0]  prtirq_q;        // printer interrupt select
    logic [7:0]  uartirq_q;       // uart interrupt select
    logic [7:0]  fdirq_q;         // floppy / external interrupt select
    logic [7:0]  clksel_q;        // input clock select
    logic [7:0]  fdrate_q;        // floppy rate / precomp control
    logic        dsel_seen_q;     // last seen defaults select level
    pnprc_acc_t  acc_q;           // last data port access, for checks
    logic        reload;          // defaults select toggled
    logic        wr_en;           // data port write taken

    // one-hot pin decode of a legacy routing nibble
    function automatic logic [7:0] pin_hot(input logic [3:0] sel);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (sel == 4'(i + 1)) begin
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : pin_hot

    // one-hot frame slot decode; smi slot never carries a device irq
    function automatic logic [15:0] slot_hot(input logic [3:0] sel);
        logic [15:0] r;
        r = 16'h0000;
        if (sel != `PNPRC_SEL_NONE && sel != `PNPRC_SLOT_SMI) begin
            r[sel] = 1'b1;
        end
        return r;
    endfunction : slot_hot

    // one-hot dma channel decode, codes above 3 select nothing
    function automatic logic [2:0] dma_hot(input logic [3:0] sel);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (sel == 4'(i + 1)) begin
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : dma_hot

    // rate table; drive code 11 is undefined, treated as code 00
    function automatic pnprc_rate_t rate_of(input logic [1:0] code,
                                            input logic [1:0] sel,
                                            input logic       fm);
        pnprc_rate_t m;
        m = PNPRC_R500K;
        case (sel)
            2'h3:    m = PNPRC_R1M;
            2'h0:    m = PNPRC_R500K;
            2'h2:    m = PNPRC_R250K;
            2'h1: begin
                case (code)
                    2'h1:    m = PNPRC_R500K;
                    2'h2:    m = PNPRC_R2M;
                    default: m = PNPRC_R300K;
                endcase
            end
            default: m = PNPRC_R500K;
        endcase
        if (!fm) begin
            return m;
        end
        case (m)
            PNPRC_R500K: return PNPRC_R250K;
            PNPRC_R300K: return PNPRC_R150K;
            PNPRC_R250K: return PNPRC_R125K;
            default:     return PNPRC_RBAD;
        endcase
    endfunction : rate_of

    // a change of the defaults level is the only reload trigger
    assign reload = (defaults_select_bit != dsel_seen_q);
    assign wr_en  = ext_mode_active && config_data_port_wr;

    // index register, held while outside extended mode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            index_q <= 8'h00;
        end else if (ext_mode_active && config_index_port_wr) begin
            index_q <= host_wdata;
        end
    end

    // track defaults level so a same-value write changes nothing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // follow the level in reset too, so release brings no false reload
            dsel_seen_q <= defaults_select_bit;
        end else begin
            dsel_seen_q <= defaults_select_bit;
        end
    end

    // strap-dependent registers; reload beats a data write
    always_ff @(posedge ref_clk) begin
        if (rst || reload) begin
            if (defaults_select_bit) begin
                ubbase_q  <= `PNPRC_DEF1_UBBASE;
                dmasel_q  <= `PNPRC_DEF1_DMASEL;
                prtirq_q  <= `PNPRC_DEF1_PRTIRQ;
                uartirq_q <= `PNPRC_DEF1_UARTIRQ;
                fdirq_q   <= `PNPRC_DEF1_FDIRQ;
            end else begin
                ubbase_q  <= `PNPRC_DEF0;
                dmasel_q  <= `PNPRC_DEF0;
                prtirq_q  <= `PNPRC_DEF0;
                uartirq_q <= `PNPRC_DEF0;
                fdirq_q   <= `PNPRC_DEF0;
            end
        end else if (wr_en) begin
            case (index_q)
                `PNPRC_IDX_UBBASE:  ubbase_q  <= host_wdata & `PNPRC_MASK_UBBASE;
                `PNPRC_IDX_DMASEL:  dmasel_q  <= host_wdata;
                `PNPRC_IDX_PRTIRQ:  prtirq_q  <= host_wdata & `PNPRC_MASK_PRTIRQ;
                `PNPRC_IDX_UARTIRQ: uartirq_q <= host_wdata;
                `PNPRC_IDX_FDIRQ:   fdirq_q   <= host_wdata;
                default: begin
                    // other indices belong to other banks
                end
            endcase
        end
    end

    // strap-independent registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clksel_q <= `PNPRC_RST_CLKSEL;
            fdrate_q <= `PNPRC_RST_FDRATE;
        end else if (wr_en && index_q == `PNPRC_IDX_CLKSEL) begin
            clksel_q <= host_wdata & `PNPRC_MASK_CLKSEL;
        end else if (wr_en && index_q == `PNPRC_IDX_FDRATE) begin
            fdrate_q <= host_wdata & `PNPRC_MASK_FDRATE;
        end
    end

    // read data; unmapped index reads zero, outside mode the last value holds
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            config_rdata_q <= 8'h00;
        end else if (ext_mode_active && config_data_port_rd) begin
            case (index_q)
                `PNPRC_IDX_UBBASE:  config_rdata_q <= ubbase_q;
                `PNPRC_IDX_DMASEL:  config_rdata_q <= dmasel_q;
                `PNPRC_IDX_PRTIRQ:  config_rdata_q <= prtirq_q;
                `PNPRC_IDX_UARTIRQ: config_rdata_q <= uartirq_q;
                `PNPRC_IDX_FDIRQ:   config_rdata_q <= fdirq_q;
                `PNPRC_IDX_CLKSEL:  config_rdata_q <= clksel_q;
                `PNPRC_IDX_FDRATE:  config_rdata_q <= fdrate_q;
                default:            config_rdata_q <= 8'h00;
            endcase
        end
    end

    // access phase log, read only by the checks below
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_q <= PNPRC_IDLE;
        end else if (wr_en) begin
            acc_q <= PNPRC_WRITE;
        end else if (ext_mode_active && config_data_port_rd) begin
            acc_q <= PNPRC_READ;
        end else begin
            acc_q <= PNPRC_IDLE;
        end
    end

    // uart b decode; registered, so claim lags the address by one edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            second_serial_claim_q <= 1'b0;
        end else begin
            second_serial_claim_q <= !chip_select_low_n && !host_addr[10]
                && (ubbase_q[7:6] != 2'b00)
                && (host_addr[9:3] == ubbase_q[7:1]);
        end
    end

    // legacy pins: selected pins driven with source level, rest released
    always_ff @(posedge ref_clk) begin
        if (rst || serial_interrupt_mode) begin
            irq_pin_out_q <= 8'h00;
            irq_pin_oe_q  <= 8'h00;
        end else begin
            irq_pin_oe_q  <= pin_hot(prtirq_q[3:0])
                | pin_hot(uartirq_q[7:4]) | pin_hot(uartirq_q[3:0])
                | pin_hot(fdirq_q[7:4]) | pin_hot(fdirq_q[3:0]);
            irq_pin_out_q <= (pin_hot(prtirq_q[3:0]) & {8{printer_irq}})
                | (pin_hot(uartirq_q[7:4]) & {8{first_serial_irq}})
                | (pin_hot(uartirq_q[3:0]) & {8{second_serial_irq}})
                | (pin_hot(fdirq_q[7:4]) & {8{floppy_irq}})
                | (pin_hot(fdirq_q[3:0]) & {8{external_interrupt_input}});
        end
    end

    // serial frame slots carry active sources in serial mode only
    always_ff @(posedge ref_clk) begin
        if (rst || !serial_interrupt_mode) begin
            serial_irq_slot_q <= 16'h0000;
        end else begin
            serial_irq_slot_q <= (slot_hot(prtirq_q[3:0]) & {16{printer_irq}})
                | (slot_hot(uartirq_q[7:4]) & {16{first_serial_irq}})
                | (slot_hot(uartirq_q[3:0]) & {16{second_serial_irq}})
                | (slot_hot(fdirq_q[7:4]) & {16{floppy_irq}})
                | (slot_hot(fdirq_q[3:0]) & {16{external_interrupt_input}});
        end
    end

    // dma channel requests, two requesters may share a channel
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dma_channel_req_q <= 3'h0;
        end else begin
            dma_channel_req_q <= (dma_hot(dmasel_q[7:4]) & {3{floppy_dma_req}})
                | (dma_hot(dmasel_q[3:0]) & {3{printer_dma_req}});
        end
    end

    // mirrored irq number and clock select
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ecp_configuration_b_irq_q <= 3'h0;
            input_clock_48m_q         <= 1'b0;
        end else begin
            ecp_configuration_b_irq_q <= prtirq_q[7:5];
            input_clock_48m_q         <= clksel_q[`PNPRC_CLK48_BIT];
        end
    end

    // floppy rate and precomp for the drive in use
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            floppy_rate_q       <= PNPRC_R500K;
            floppy_precomp_en_q <= 1'b1;
        end else if (floppy_drive_b) begin
            floppy_rate_q       <= rate_of(fdrate_q[4:3],
                {rate_select_high, rate_select_low}, floppy_fm_mode);
            floppy_precomp_en_q <= !fdrate_q[`PNPRC_PCB_B_BIT];
        end else begin
            floppy_rate_q       <= rate_of(fdrate_q[1:0],
                {rate_select_high, rate_select_low}, floppy_fm_mode);
            floppy_precomp_en_q <= !fdrate_q[`PNPRC_PCA_A_BIT];
        end
    end

    // write then read of the same index
    sequence s_wr_base;
        wr_en && index_q == `PNPRC_IDX_UBBASE && !reload;
    endsequence
    sequence s_rd_base;
        ext_mode_active && config_data_port_rd && index_q == `PNPRC_IDX_UBBASE;
    endsequence

    a_base_bit_zero: assert property (@(posedge ref_clk) disable iff (rst)
        s_wr_base |=> ubbase_q[0] == 1'b0 && ubbase_q[7:1] == $past(host_wdata[7:1]))
        else $error("uart b base write lost or bit 0 set");
    a_out_of_mode: assert property (@(posedge ref_clk) disable iff (rst)
        !ext_mode_active && config_data_port_rd |=> $stable(config_rdata_q))
        else $error("read served outside extended mode");
    a_read_back: assert property (@(posedge ref_clk) disable iff (rst)
        s_rd_base ##1 acc_q == PNPRC_READ |-> config_rdata_q == $past(ubbase_q))
        else $error("base read back wrong");
    a_decode_off: assert property (@(posedge ref_clk) disable iff (rst)
        ubbase_q[7:6] == 2'b00 ##1 $stable(ubbase_q) |-> !second_serial_claim_q)
        else $error("claim while decode disabled");
    a_claim_gate: assert property (@(posedge ref_clk) disable iff (rst)
        chip_select_low_n || host_addr[10] |=> !second_serial_claim_q)
        else $error("claim without select or with a10");
    a_serial_tri: assert property (@(posedge ref_clk) disable iff (rst)
        serial_interrupt_mode |=> irq_pin_oe_q == 8'h00)
        else $error("pin driven in serial mode");
    a_reload_dflt: assert property (@(posedge ref_clk) disable iff (rst)
        reload && defaults_select_bit |=> ubbase_q == `PNPRC_DEF1_UBBASE
            && dmasel_q == `PNPRC_DEF1_DMASEL)
        else $error("defaults not applied");
    a_reload_irq: assert property (@(posedge ref_clk) disable iff (rst)
        reload && !defaults_select_bit |=> prtirq_q == 8'h00 && fdirq_q == 8'h00)
        else $error("irq defaults not cleared");
    a_precomp_a: assert property (@(posedge ref_clk) disable iff (rst)
        !floppy_drive_b && fdrate_q[`PNPRC_PCA_A_BIT] |=> !floppy_precomp_en_q)
        else $error("drive a precomp not disabled");
    a_fm_high: assert property (@(posedge ref_clk) disable iff (rst)
        floppy_fm_mode && rate_select_high && rate_select_low |=> floppy_rate_q == PNPRC_RBAD)
        else $error("fm rate at 1m setting");
    a_ecp_mirror: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(prtirq_q[7:5]) |=> ecp_configuration_b_irq_q == $past(prtirq_q[7:5]))
        else $error("config b mirror stale");

endmodule : pnprc_regs
`default_nettype wire

// file: pnprc_host.sv
// host side model: config index/data port cycles and the defaults select level
`timescale 1ns/1ps
`default_nettype none

module pnprc_host (
    input  wire logic       ref_clk,
    output logic            ext_on,
    output logic            idx_wr,
    output logic            dat_wr,
    output logic            dat_rd,
    output logic [7:0]      wdata,
    output logic            dflt
);
    // idle port, extended mode entered, defaults select high
    initial begin
        ext_on = 1'b1;
        idx_wr = 1'b0;
        dat_wr = 1'b0;
        dat_rd = 1'b0;
        wdata  = 8'h00;
        dflt   = 1'b1;
    end

    // index write, then one data strobe; values chosen by software
    task automatic acc(input logic [7:0] idx, input logic [7:0] val, input logic rd);
        @(posedge ref_clk);
        idx_wr <= 1'b1;
        wdata  <= idx;
        @(posedge ref_clk);
        idx_wr <= 1'b0;
        dat_wr <= !rd;
        dat_rd <= rd;
        wdata  <= val;
        @(posedge ref_clk);
        dat_wr <= 1'b0;
        dat_rd <= 1'b0;
        // released data lines show the inverse, not a stale value
        wdata  <= ~val;
    endtask : acc

    // besides reset, only a change of level brings defaults back
    task automatic set_dflt(input logic b);
        @(posedge ref_clk);
        dflt <= b;
    endtask : set_dflt

    // leave or re-enter extended function mode
    task automatic set_ext(input logic b);
        @(posedge ref_clk);
        ext_on <= b;
    endtask : set_ext
endmodule : pnprc_host

`default_nettype wire

// file: tb.sv
// self-checking bench for the pnp resource bank
`timescale 1ns/1ps
`default_nettype none

module tb
    import pnprc_pkg::*;
();
    logic        ref_clk, rst, cs_n, smode, pirq, airq, birq, firq, xirq;
    logic        fdreq, prreq, drv_b, rhi, rlo, fm;
    logic        ext_on, idx_wr, dat_wr, dat_rd, dflt, claim, c48, pce;
    logic [10:0] addr;
    logic [7:0]  wdata, rdata, pout, poe;
    logic [15:0] slot;
    logic [2:0]  dma, ecp;
    pnprc_rate_t rate;
    logic [7:0]  m [256];  // register model
    int          n_errors, samples_checked, seed;

    pnprc_host host_u (.ref_clk(ref_clk), .ext_on(ext_on), .idx_wr(idx_wr), .dat_wr(dat_wr),
        .dat_rd(dat_rd), .wdata(wdata), .dflt(dflt));

    pnprc_regs dut_u (.ref_clk(ref_clk), .rst(rst), .ext_mode_active(ext_on),
        .config_index_port_wr(idx_wr), .config_data_port_wr(dat_wr),
        .config_data_port_rd(dat_rd), .host_wdata(wdata), .config_rdata_q(rdata),
        .defaults_select_bit(dflt), .host_addr(addr), .chip_select_low_n(cs_n),
        .second_serial_claim_q(claim), .serial_interrupt_mode(smode), .printer_irq(pirq),
        .first_serial_irq(airq), .second_serial_irq(birq), .floppy_irq(firq),
        .external_interrupt_input(xirq), .irq_pin_out_q(pout), .irq_pin_oe_q(poe),
        .serial_irq_slot_q(slot), .floppy_dma_req(fdreq), .printer_dma_req(prreq),
        .dma_channel_req_q(dma), .ecp_configuration_b_irq_q(ecp), .input_clock_48m_q(c48),
        .floppy_drive_b(drv_b), .rate_select_high(rhi), .rate_select_low(rlo),
        .floppy_fm_mode(fm), .floppy_rate_q(rate), .floppy_precomp_en_q(pce));

    // free running 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // one comparison, counted; four-state so an unknown only matches an unknown
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // writable bits per index; unmapped places hold nothing
    function automatic logic [7:0] msk(input int i);
        case (i)
            8'h25: return 8'hFE;
            8'h26, 8'h28, 8'h29: return 8'hFF;
            8'h27: return 8'hEF;
            8'h2C: return 8'h04;
            8'h2D: return 8'h3F;
            default: return 8'h00;
        endcase
    endfunction : msk

    // pnp defaults follow the select level
    task automatic mdef(input logic b);
        m[8'h25] = b ? 8'hBE : 8'h00;
        m[8'h26] = b ? 8'h23 : 8'h00;
        m[8'h27] = b ? 8'h05 : 8'h00;
        m[8'h28] = b ? 8'h43 : 8'h00;
        m[8'h29] = b ? 8'h62 : 8'h00;
    endtask : mdef

    // register write through the host, model kept alongside
    task automatic wr(input int i, input logic [7:0] v);
        m[i] = v & msk(i);
        host_u.acc(8'(i), v, 1'b1 == 1'b0);
    endtask : wr

    // read through the host and compare with the model
    task automatic rd_chk(input int i);
        host_u.acc(8'(i), 8'($urandom), 1'b1);
        #1 chk(rdata, m[i]);
    endtask : rd_chk

    // synchronous reset for four cycles with a given defaults level
    task automatic rst_run(input logic b);
        host_u.set_dflt(b);
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (m[i]) m[i] = 8'h00;
        mdef(b);
    endtask : rst_run

    // random inputs for one cycle, then every derived output against the model
    task automatic step();
        logic [7:0]  eo, ee;
        logic [15:0] es;
        logic [2:0]  ed;
        logic [3:0]  c [5];
        logic        s [5];
        logic [1:0]  dc;
        int          k;
        pnprc_rate_t er;
        @(posedge ref_clk);
        // half the addresses aim at the programmed base
        addr  <= ($urandom % 2) ? {1'b0, m[8'h25][7:1], 3'($urandom)} : 11'($urandom);
        cs_n  <= ($urandom % 4) == 0;
        {smode, pirq, airq, birq, firq, xirq} <= 6'($urandom);
        {fdreq, prreq, drv_b, rhi, rlo, fm} <= 6'($urandom);
        @(posedge ref_clk);
        #1;
        eo = 8'h00;
        ee = 8'h00;
        es = 16'h0000;
        ed = 3'h0;
        c = '{m[8'h27][3:0], m[8'h28][7:4], m[8'h28][3:0], m[8'h29][7:4], m[8'h29][3:0]};
        s = '{pirq, airq, birq, firq, xirq};
        for (int i = 0; i < 5; i++) begin
            // legacy pins A..H for codes 1..8, a shared pin ors its sources
            if (c[i] inside {[1:8]}) begin
                ee[c[i] - 4'd1] = 1'b1;
                eo[c[i] - 4'd1] |= s[i];
            end
            // slot 2 stays reserved for the management interrupt
            if (c[i] != 4'h0 && c[i] != 4'h2) es[c[i]] |= s[i];
        end
        if (m[8'h26][7:4] inside {[1:3]}) ed[m[8'h26][7:4] - 4'd1] |= fdreq;
        if (m[8'h26][3:0] inside {[1:3]}) ed[m[8'h26][3:0] - 4'd1] |= prreq;
        dc = drv_b ? m[8'h2D][4:3] : m[8'h2D][1:0];
        case ({rhi, rlo})
            2'b11: k = 1000;
            2'b00: k = 500;
            2'b10: k = 250;
            default: k = (dc == 2'b01) ? 500 : (dc == 2'b10) ? 2000 : 300;
        endcase
        // fm halves the rate, nothing exists at 1M or 2M
        if (fm) k = (k >= 1000) ? 0 : k / 2;
        case (k)
            2000: er = PNPRC_R2M;
            1000: er = PNPRC_R1M;
            500: er = PNPRC_R500K;
            300: er = PNPRC_R300K;
            250: er = PNPRC_R250K;
            150: er = PNPRC_R150K;
            125: er = PNPRC_R125K;
            default: er = PNPRC_RBAD;
        endcase
        chk(claim, !cs_n && !addr[10] && m[8'h25][7:6] != 2'b00 && addr[9:3] == m[8'h25][7:1]);
        if (smode) begin
            chk(poe, 8'h00);
            chk(pout, 8'h00);
            chk(slot, es);
        end else begin
            chk(poe, ee);
            chk(pout, eo);
            chk(slot, 16'h0000);
        end
        chk(dma, ed);
        chk(ecp, m[8'h27][7:5]);
        chk(c48, m[8'h2C][2]);
        chk(rate, er);
        chk(pce, !(drv_b ? m[8'h2D][5] : m[8'h2D][2]));
    endtask : step

    // the verdict, reached from the main sequence or the watchdog
    task automatic results();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        n_errors = 0;
        samples_checked = 0;
        seed = $urandom(32'h0C5144C7);
        rst = 1'b1;
        addr = 11'h000;
        {cs_n, smode, pirq, airq, birq, firq, xirq} = 7'h40;
        {fdreq, prreq, drv_b, rhi, rlo, fm} = 6'h00;
        rst_run(1'b1);
        for (int i = 8'h24; i <= 8'h2E; i++) rd_chk(i);
        repeat (4) step();
        for (int i = 8'h24; i <= 8'h2E; i++) wr(i, 8'hFF);
        for (int i = 8'h24; i <= 8'h2E; i++) rd_chk(i);
        // writes, index writes and reads outside extended mode must be dropped
        rd_chk(8'h25);
        host_u.set_ext(1'b0);
        host_u.acc(8'h25, 8'h00, 1'b0);
        host_u.acc(8'h2D, 8'h00, 1'b1);
        #1 chk(rdata, m[8'h25]);
        host_u.set_ext(1'b1);
        rd_chk(8'h25);
        // sweep every nibble code through the printer irq, dma, base and rate selectors
        for (int k = 0; k < 16; k++) begin
            wr(8'h27, 8'(k * 37));
            wr(8'h26, 8'(k * 8'h11));
            wr(8'h25, 8'(k * 8'h1F));
            wr(8'h2D, 8'(k * 8'h0B));
            repeat (4) step();
        end
        // defaults come back on a level change of the select
        host_u.set_dflt(1'b0);
        repeat (2) @(posedge ref_clk);
        mdef(1'b0);
        for (int i = 8'h25; i <= 8'h29; i++) rd_chk(i);
        host_u.set_dflt(1'b1);
        repeat (2) @(posedge ref_clk);
        mdef(1'b1);
        for (int i = 8'h25; i <= 8'h29; i++) rd_chk(i);
        rst_run(1'b0);
        for (int i = 8'h25; i <= 8'h2D; i++) rd_chk(i);
        // random traffic mixed with output checks
        repeat (60) begin
            int i;
            i = 8'h25 + $urandom % 9;
            wr(i, 8'($urandom));
            rd_chk(i);
            repeat (3) step();
        end
        results();
    end

    // watchdog well beyond the roughly 1230 cycles the run needs
    initial begin
        #200us;
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule : tb

`default_nettype wire
